// *** src/bpt_defs.svh ***
// register map, field positions and reset values of the boost phase timing block
`ifndef BPT_DEFS_SVH
`define BPT_DEFS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define BPT_ADDR_GATE_EN 7'h01
`define BPT_ADDR_DIV1 7'h09
`define BPT_ADDR_DIV2 7'h0A
`define BPT_ADDR_PHASE1 7'h0D
`define BPT_ADDR_PHASE2 7'h0E
`define BPT_ADDR_PROP 7'h11
`define BPT_ADDR_INTEG 7'h12
`define BPT_ADDR_SLOPE 7'h13
`define BPT_ADDR_SENSE 7'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define BPT_GATE_EN_MSB 1
`define BPT_SENSE_MSB 3
`define BPT_DELAY_MSB 7
`define BPT_DELAY_LSB 3
`define BPT_OFF_MSB 2
`define BPT_OFF_LSB 0
`define BPT_LO_NIB_MSB 3
`define BPT_LO_NIB_LSB 0
`define BPT_HI_NIB_MSB 7
`define BPT_HI_NIB_LSB 4
`define BPT_RES1_MSB 1
`define BPT_RES1_LSB 0
`define BPT_RES2_MSB 3
`define BPT_RES2_LSB 2

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define BPT_RST_BYTE 8'h00
`define BPT_RST_GATE 2'h0
`define BPT_RST_SENSE 4'h0
`define BPT_OFF_MIN 3'h1
`define BPT_OFF_ZERO 3'h0
`define BPT_ZERO6 6'h00
`define BPT_ONE6 6'h01
`define BPT_ZERO8 8'h00
`define BPT_ONE8 8'h01

// ----------------------------------------
// serial frame layout
// ----------------------------------------
`define BPT_FRAME_BITS 5'h10
`define BPT_ADDR_BITS 5'h08
`define BPT_ZERO5 5'h00
`define BPT_ONE5 5'h01
`define BPT_RW_BIT 7
`define BPT_MISO_BIT 7
`define BPT_FRAME_ADDR_MSB 14
`define BPT_FRAME_ADDR_LSB 8
`define BPT_FRAME_DATA_MSB 7
`define BPT_FRAME_DATA_LSB 0
`define BPT_RST_SHIFT 15'h0000

`endif

// *** src/bpt_pkg.sv ***
// types shared by the boost phase timing block
package bpt_pkg;

  // per output timing and loop settings
  typedef struct packed {
    logic [7:0] oscDivisor;
    logic [4:0] interphaseDelay;
    logic [2:0] offTime;
    logic [3:0] propGain;
    logic [3:0] integralGain;
    logic [3:0] slopeComp;
  } bpt_loop_cfg_type;

  // per gate driver settings
  typedef struct packed {
    logic [1:0] slopeRes;
  } bpt_drv_cfg_type;

  // phase sequencer states
  typedef enum logic [1:0] {
    BPT_SEQ_IDLE = 2'b00,
    BPT_SEQ_ON = 2'b01,
    BPT_SEQ_OFF = 2'b10
  } bpt_seq_type;

endpackage : bpt_pkg

// *** src/bpt_boost_phase_timing.sv ***
// boost phase timing: serial register file, oscillator dividers and phase generators
// Notes on behaviour
// R1: phase drives only while its enable bit set
// R2: host keeps gate enable bits 7:2 zero
// R3: all phase timing from one oscillator
// R4: output 1 divides oscillator by code plus one
// R5: output 2 has own divider, code plus one
// R6: off-time and delay counted in divided ticks
// R7: phase restarts after full loop delay elapses
// R8: delay field gives code plus one periods
// R9: off field gives code periods, zero gives one
// R10: host should keep delay near 32 periods
// R11: proportional codes, output 1 low nibble
// R12: integral codes, output 1 low nibble
// R13: slope compensation codes per output nibble
// R14: sense resistor codes, two bits per driver
// R15: host matches settings to external components
// R16: configuration writes locked once config finished
// R17: disabled phase low, restarts from defined state
`timescale 1ns/10ps
`include "bpt_defs.svh"

module bpt_boost_phase_timing (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // serial register port, synchronous to clk_sys
  input wire logic spiSclk,
  input wire logic spiCsB,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // device mode and output enables
  input wire logic configFinished,
  input wire logic [1:0] outputEnable,
  // gate drive per physical phase
  output logic phase1DriveOn,
  output logic phase2DriveOn,
  // configuration to the analog loop
  output bpt_pkg::bpt_loop_cfg_type firstOutputCfg,
  output bpt_pkg::bpt_loop_cfg_type secondOutputCfg,
  output bpt_pkg::bpt_drv_cfg_type driver1Cfg,
  output bpt_pkg::bpt_drv_cfg_type driver2Cfg
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [1:0] gateEnable_reg, gateEnable_next;
  logic [7:0] div1_reg, div1_next;
  logic [7:0] div2_reg, div2_next;
  logic [7:0] phase1_reg, phase1_next;
  logic [7:0] phase2_reg, phase2_next;
  logic [7:0] prop_reg, prop_next;
  logic [7:0] integ_reg, integ_next;
  logic [7:0] slope_reg, slope_next;
  logic [3:0] sense_reg, sense_next;

  // serial engine state
  logic sclkPrev_reg, sclkPrev_next;
  logic [4:0] bitCnt_reg, bitCnt_next;
  logic [14:0] shiftIn_reg, shiftIn_next;
  logic [7:0] shiftOut_reg, shiftOut_next;
  logic miso_reg, miso_next;
  logic misoOe_reg, misoOe_next;

  logic sclkRise;
  logic sclkFall;
  logic [15:0] frame;
  logic writeStrobe;
  logic [6:0] frameAddr;
  logic [7:0] frameData;

  // readback mux, reserved bits read zero
  // unmapped addresses read zero as well
  function automatic logic [7:0] readReg(input logic [6:0] addr, input logic [1:0] ge,
      input logic [7:0] d1, input logic [7:0] d2, input logic [7:0] p1, input logic [7:0] p2,
      input logic [7:0] pr, input logic [7:0] ig, input logic [7:0] sl, input logic [3:0] se);
    logic [7:0] val;
    val = `BPT_ZERO8;
    if (addr == `BPT_ADDR_GATE_EN) begin
      val = {6'h00, ge};
    end else if (addr == `BPT_ADDR_DIV1) begin
      val = d1;
    end else if (addr == `BPT_ADDR_DIV2) begin
      val = d2;
    end else if (addr == `BPT_ADDR_PHASE1) begin
      val = p1;
    end else if (addr == `BPT_ADDR_PHASE2) begin
      val = p2;
    end else if (addr == `BPT_ADDR_PROP) begin
      val = pr;
    end else if (addr == `BPT_ADDR_INTEG) begin
      val = ig;
    end else if (addr == `BPT_ADDR_SLOPE) begin
      val = sl;
    end else if (addr == `BPT_ADDR_SENSE) begin
      val = {4'h0, se};
    end
    return val;
  endfunction : readReg

  // sclk edges seen against the previous clk sample
  assign sclkRise = spiSclk & ~sclkPrev_reg;
  assign sclkFall = ~spiSclk & sclkPrev_reg;
  // frame as it stands with the bit on mosi now
  assign frame = {shiftIn_reg, spiMosi};
  assign frameAddr = frame[`BPT_FRAME_ADDR_MSB:`BPT_FRAME_ADDR_LSB];
  assign frameData = frame[`BPT_FRAME_DATA_MSB:`BPT_FRAME_DATA_LSB];
  // R16: writes ignored once locked
  // a locked write is dropped without any indication
  assign writeStrobe = sclkRise && !spiCsB && (bitCnt_reg == `BPT_FRAME_BITS - `BPT_ONE5)
      && frame[`BPT_RW_BIT + 8] && !configFinished;

  // serial shift engine, mode 0, msb first
  always_comb begin
    sclkPrev_next = spiSclk;
    bitCnt_next = bitCnt_reg;
    shiftIn_next = shiftIn_reg;
    shiftOut_next = shiftOut_reg;
    miso_next = miso_reg;
    misoOe_next = !spiCsB;
    if (spiCsB) begin
      bitCnt_next = `BPT_ZERO5;
      shiftOut_next = `BPT_ZERO8;
      miso_next = 1'b0;
    end else begin
      if (sclkRise) begin
        shiftIn_next = frame[14:0];
        bitCnt_next = (bitCnt_reg == `BPT_FRAME_BITS - `BPT_ONE5) ? `BPT_ZERO5 : bitCnt_reg + `BPT_ONE5;
        if (bitCnt_reg == `BPT_ADDR_BITS - `BPT_ONE5) begin
          shiftOut_next = readReg(frame[6:0], gateEnable_reg, div1_reg, div2_reg, phase1_reg,
              phase2_reg, prop_reg, integ_reg, slope_reg, sense_reg);
        end
      end
      if (sclkFall && bitCnt_reg >= `BPT_ADDR_BITS) begin
        miso_next = shiftOut_reg[`BPT_MISO_BIT];
        shiftOut_next = {shiftOut_reg[6:0], 1'b0};
      end
    end
  end

  // serial engine registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sclkPrev_reg <= 1'b0;
      bitCnt_reg <= `BPT_ZERO5;
      shiftIn_reg <= `BPT_RST_SHIFT;
      shiftOut_reg <= `BPT_ZERO8;
      miso_reg <= 1'b0;
      misoOe_reg <= 1'b0;
    end else begin
      sclkPrev_reg <= sclkPrev_next;
      bitCnt_reg <= bitCnt_next;
      shiftIn_reg <= shiftIn_next;
      shiftOut_reg <= shiftOut_next;
      miso_reg <= miso_next;
      misoOe_reg <= misoOe_next;
    end
  end

  // register write decode
  always_comb begin
    gateEnable_next = gateEnable_reg;
    div1_next = div1_reg;
    div2_next = div2_reg;
    phase1_next = phase1_reg;
    phase2_next = phase2_reg;
    prop_next = prop_reg;
    integ_next = integ_reg;
    slope_next = slope_reg;
    sense_next = sense_reg;
    if (writeStrobe) begin
      if (frameAddr == `BPT_ADDR_GATE_EN) begin
        gateEnable_next = frameData[`BPT_GATE_EN_MSB:0];
      end else if (frameAddr == `BPT_ADDR_DIV1) begin
        div1_next = frameData;
      end else if (frameAddr == `BPT_ADDR_DIV2) begin
        div2_next = frameData;
      end else if (frameAddr == `BPT_ADDR_PHASE1) begin
        phase1_next = frameData;
      end else if (frameAddr == `BPT_ADDR_PHASE2) begin
        phase2_next = frameData;
      end else if (frameAddr == `BPT_ADDR_PROP) begin
        prop_next = frameData;
      end else if (frameAddr == `BPT_ADDR_INTEG) begin
        integ_next = frameData;
      end else if (frameAddr == `BPT_ADDR_SLOPE) begin
        slope_next = frameData;
      end else if (frameAddr == `BPT_ADDR_SENSE) begin
        sense_next = frameData[`BPT_SENSE_MSB:0];
      end
    end
  end

  // register file flops, cleared by reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      gateEnable_reg <= `BPT_RST_GATE;
      div1_reg <= `BPT_RST_BYTE;
      div2_reg <= `BPT_RST_BYTE;
      phase1_reg <= `BPT_RST_BYTE;
      phase2_reg <= `BPT_RST_BYTE;
      prop_reg <= `BPT_RST_BYTE;
      integ_reg <= `BPT_RST_BYTE;
      slope_reg <= `BPT_RST_BYTE;
      sense_reg <= `BPT_RST_SENSE;
    end else begin
      gateEnable_reg <= gateEnable_next;
      div1_reg <= div1_next;
      div2_reg <= div2_next;
      phase1_reg <= phase1_next;
      phase2_reg <= phase2_next;
      prop_reg <= prop_next;
      integ_reg <= integ_next;
      slope_reg <= slope_next;
      sense_reg <= sense_next;
    end
  end

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  // R11: proportional nibbles
  // R12: integral nibbles
  // R13: slope compensation nibbles
  assign firstOutputCfg = '{oscDivisor: div1_reg,
      interphaseDelay: phase1_reg[`BPT_DELAY_MSB:`BPT_DELAY_LSB],
      offTime: phase1_reg[`BPT_OFF_MSB:`BPT_OFF_LSB],
      propGain: prop_reg[`BPT_LO_NIB_MSB:`BPT_LO_NIB_LSB],
      integralGain: integ_reg[`BPT_LO_NIB_MSB:`BPT_LO_NIB_LSB],
      slopeComp: slope_reg[`BPT_LO_NIB_MSB:`BPT_LO_NIB_LSB]};
  assign secondOutputCfg = '{oscDivisor: div2_reg,
      interphaseDelay: phase2_reg[`BPT_DELAY_MSB:`BPT_DELAY_LSB],
      offTime: phase2_reg[`BPT_OFF_MSB:`BPT_OFF_LSB],
      propGain: prop_reg[`BPT_HI_NIB_MSB:`BPT_HI_NIB_LSB],
      integralGain: integ_reg[`BPT_HI_NIB_MSB:`BPT_HI_NIB_LSB],
      slopeComp: slope_reg[`BPT_HI_NIB_MSB:`BPT_HI_NIB_LSB]};
  // R14: two sense resistor bits per driver
  assign driver1Cfg = '{slopeRes: sense_reg[`BPT_RES1_MSB:`BPT_RES1_LSB]};
  assign driver2Cfg = '{slopeRes: sense_reg[`BPT_RES2_MSB:`BPT_RES2_LSB]};

  // serial pins straight from their flops
  assign spiMiso = miso_reg;
  assign spiMisoOe = misoOe_reg;

  // ----------------------------------------
  // phase generators, loop n drives phase n
  // ----------------------------------------
  logic [1:0] gate_reg;
  logic [7:0] divSel [2];
  logic [7:0] phaseSel [2];

  // per loop views of the timing registers
  assign divSel[0] = div1_reg;
  assign divSel[1] = div2_reg;
  assign phaseSel[0] = phase1_reg;
  assign phaseSel[1] = phase2_reg;

  // one sequencer per regulation loop, shared oscillator
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_loop
      // divider and phase counters of this loop
      logic [7:0] divCnt_reg, divCnt_next;
      logic [5:0] phCnt_reg, phCnt_next;
      bpt_pkg::bpt_seq_type seq_reg, seq_next;
      logic gate_next;
      logic active;
      logic tick;
      logic [5:0] delayTicks;
      logic [5:0] offTicks;
      logic [5:0] onTicks;

      // R1: phase only runs while enabled
      assign active = gateEnable_reg[g] && outputEnable[g];
      // R3: R4: R5: divider from the shared oscillator
      assign tick = (divCnt_reg == divSel[g]);
      // R8: delay is code plus one
      assign delayTicks = {1'b0, phaseSel[g][`BPT_DELAY_MSB:`BPT_DELAY_LSB]} + `BPT_ONE6;
      // R9: off code zero gives one period
      assign offTicks = (phaseSel[g][`BPT_OFF_MSB:`BPT_OFF_LSB] == `BPT_OFF_ZERO) ?
          {3'h0, `BPT_OFF_MIN} : {3'h0, phaseSel[g][`BPT_OFF_MSB:`BPT_OFF_LSB]};
      // off-time not below the period keeps the gate low
      assign onTicks = (delayTicks > offTicks) ? delayTicks - offTicks : `BPT_ZERO6;

      // sequencer: on for period minus off-time, then off
      always_comb begin
        divCnt_next = divCnt_reg;
        phCnt_next = phCnt_reg;
        seq_next = seq_reg;
        gate_next = gate_reg[g];
        case (seq_reg)
          bpt_pkg::BPT_SEQ_IDLE: begin
            // restart point, counters cleared
            divCnt_next = `BPT_ZERO8;
            phCnt_next = `BPT_ZERO6;
            gate_next = 1'b0;
            if (active) begin
              seq_next = (onTicks != `BPT_ZERO6) ? bpt_pkg::BPT_SEQ_ON : bpt_pkg::BPT_SEQ_OFF;
              gate_next = (onTicks != `BPT_ZERO6);
            end
          end
          bpt_pkg::BPT_SEQ_ON, bpt_pkg::BPT_SEQ_OFF: begin
            // R6: counts in divided periods
            divCnt_next = tick ? `BPT_ZERO8 : divCnt_reg + `BPT_ONE8;
            if (tick) begin
              // R7: next turn-on after whole delay
              phCnt_next = (phCnt_reg == delayTicks - `BPT_ONE6) ? `BPT_ZERO6 : phCnt_reg + `BPT_ONE6;
            end
            seq_next = (phCnt_next < onTicks) ? bpt_pkg::BPT_SEQ_ON : bpt_pkg::BPT_SEQ_OFF;
            gate_next = (phCnt_next < onTicks);
          end
          default: begin
            seq_next = bpt_pkg::BPT_SEQ_IDLE;
            gate_next = 1'b0;
          end
        endcase
        // R17: disable forces low and restarts
        if (!active) begin
          seq_next = bpt_pkg::BPT_SEQ_IDLE;
          gate_next = 1'b0;
        end
      end

      // sequencer flops
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          divCnt_reg <= `BPT_ZERO8;
          phCnt_reg <= `BPT_ZERO6;
          seq_reg <= bpt_pkg::BPT_SEQ_IDLE;
          gate_reg[g] <= 1'b0;
        end else begin
          divCnt_reg <= divCnt_next;
          phCnt_reg <= phCnt_next;
          seq_reg <= seq_next;
          gate_reg[g] <= gate_next;
        end
      end
    end
  endgenerate

  // gate pins straight from the sequencer flops
  assign phase1DriveOn = gate_reg[0];
  assign phase2DriveOn = gate_reg[1];

endmodule : bpt_boost_phase_timing

// *** test/bpt_boost_phase_timing_props.sv ***
// port assertions of the boost phase timing block
`timescale 1ns/10ps
module bpt_boost_phase_timing_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // serial port
  input wire logic spiCsB,
  input wire logic spiMiso,
  input wire logic spiMisoOe,
  // mode and gates
  input wire logic configFinished,
  input wire logic [1:0] outputEnable,
  input wire logic phase1DriveOn,
  input wire logic phase2DriveOn,
  // configuration
  input wire bpt_pkg::bpt_loop_cfg_type firstOutputCfg,
  input wire bpt_pkg::bpt_loop_cfg_type secondOutputCfg,
  input wire bpt_pkg::bpt_drv_cfg_type driver1Cfg,
  input wire bpt_pkg::bpt_drv_cfg_type driver2Cfg
);
  logic [15:0] hiRun_reg, hiRun_next, loRun_reg, loRun_next, off1, off2, hiExp, loExp;
  logic p2Prev_reg, seen2_reg, seen2_next;
  // expected high and low spans in clocks
  assign off1 = (firstOutputCfg.offTime == 3'h0) ? 16'h0001 : {13'h0, firstOutputCfg.offTime};
  assign off2 = (secondOutputCfg.offTime == 3'h0) ? 16'h0001 : {13'h0, secondOutputCfg.offTime};
  assign hiExp = ({11'h0, firstOutputCfg.interphaseDelay} + 16'h0001 - off1) * ({8'h0, firstOutputCfg.oscDivisor} + 16'h0001);
  assign loExp = off2 * ({8'h0, secondOutputCfg.oscDivisor} + 16'h0001);
  // run counters, seen2 marks a full low span
  always_comb begin
    hiRun_next = phase1DriveOn ? hiRun_reg + 16'h0001 : 16'h0000;
    loRun_next = phase2DriveOn ? 16'h0000 : loRun_reg + 16'h0001;
    seen2_next = outputEnable[1] & (seen2_reg | (p2Prev_reg & ~phase2DriveOn));
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hiRun_reg <= 16'h0000;
      loRun_reg <= 16'h0000;
      p2Prev_reg <= 1'b0;
      seen2_reg <= 1'b0;
    end else begin
      hiRun_reg <= hiRun_next;
      loRun_reg <= loRun_next;
      p2Prev_reg <= phase2DriveOn;
      seen2_reg <= seen2_next;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence sel_start;
    $fell(spiCsB);
  endsequence
  sequence p1_drop;
    $fell(phase1DriveOn) && outputEnable[0] && configFinished;
  endsequence
  p1_off_a: assert property (!outputEnable[0] |=> !phase1DriveOn) else $error("phase 1 on while off");
  p2_off_a: assert property (!outputEnable[1] |=> !phase2DriveOn) else $error("phase 2 on while off");
  lock_first_a: assert property (configFinished |=> $stable(firstOutputCfg)) else $error("cfg 1 changed");
  lock_second_a: assert property (configFinished |=> $stable(secondOutputCfg)) else $error("cfg 2 changed");
  lock_drv_a: assert property (configFinished |=> $stable({driver1Cfg, driver2Cfg})) else $error("drv changed");
  oe_on_a: assert property (sel_start |=> spiMisoOe) else $error("miso enable missing");
  oe_off_a: assert property (spiCsB |=> !spiMisoOe) else $error("miso enable stuck");
  miso_idle_a: assert property (spiCsB [*2] |-> !spiMiso) else $error("miso not idle");
  p1_span_a: assert property (p1_drop |-> hiRun_reg == hiExp) else $error("phase 1 high span");
  p2_gap_a: assert property ($rose(phase2DriveOn) && seen2_reg && configFinished |-> loRun_reg == loExp) else $error("gap");
endmodule : bpt_boost_phase_timing_props
bind bpt_boost_phase_timing bpt_boost_phase_timing_props i_bpt_boost_phase_timing_props (.clk_sys(clk_sys),
  .rst_b(rst_b), .spiCsB(spiCsB), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .configFinished(configFinished),
  .outputEnable(outputEnable), .phase1DriveOn(phase1DriveOn), .phase2DriveOn(phase2DriveOn),
  .firstOutputCfg(firstOutputCfg), .secondOutputCfg(secondOutputCfg), .driver1Cfg(driver1Cfg), .driver2Cfg(driver2Cfg));

// *** test/bpt_spi_host.sv ***
// serial host model sending register frames
`timescale 1ns/10ps
module bpt_spi_host (
  // clock
  input wire logic clk_sys,
  // serial lines
  output logic spiSclk,
  output logic spiCsB,
  output logic spiMosi,
  input wire logic spiMiso
);
  // idle levels
  initial begin
    spiSclk = 1'b0;
    spiCsB = 1'b1;
    spiMosi = 1'b0;
  end
  // one frame, msb first, sclk low 3 and high 2 clocks
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rw, a, d};
    q = 8'h00;
    @(negedge clk_sys);
    spiCsB = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spiMosi = f[i];
      repeat (3) @(negedge clk_sys);
      if (i < 8) q[i] = spiMiso;
      spiSclk = 1'b1;
      repeat (2) @(negedge clk_sys);
      spiSclk = 1'b0;
    end
    @(negedge clk_sys);
    spiCsB = 1'b1;
    spiMosi = ~spiMosi;
    repeat (2) @(negedge clk_sys);
  endtask : xfer
endmodule : bpt_spi_host

// *** test/tb.sv ***
// self-checking bench of the boost phase timing block
`timescale 1ns/10ps
`include "bpt_defs.svh"
module tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic spiSclk, spiCsB, spiMosi, spiMiso, spiMisoOe, phase1DriveOn, phase2DriveOn;
  logic configFinished = 1'b0;
  logic [1:0] outputEnable = 2'h0;
  bpt_pkg::bpt_loop_cfg_type firstOutputCfg, secondOutputCfg;
  bpt_pkg::bpt_drv_cfg_type driver1Cfg, driver2Cfg;
  logic [7:0] rd;
  int bad_count = 0;
  int checks = 0;
  int hi, lo;
  // clock
  always #4 clk_sys = ~clk_sys;
  bpt_boost_phase_timing i_bpt_boost_phase_timing (.clk_sys(clk_sys), .rst_b(rst_b), .spiSclk(spiSclk),
    .spiCsB(spiCsB), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .configFinished(configFinished),
    .outputEnable(outputEnable), .phase1DriveOn(phase1DriveOn), .phase2DriveOn(phase2DriveOn),
    .firstOutputCfg(firstOutputCfg), .secondOutputCfg(secondOutputCfg), .driver1Cfg(driver1Cfg), .driver2Cfg(driver2Cfg));
  bpt_spi_host i_bpt_spi_host (.clk_sys(clk_sys), .spiSclk(spiSclk), .spiCsB(spiCsB), .spiMosi(spiMosi),
    .spiMiso(spiMiso));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_bpt_spi_host.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp, input string what);
    i_bpt_spi_host.xfer(1'b0, a, 8'h00, rd);
    check(rd, exp, what);
  endtask : rdc
  // waits for a fresh rise, then counts high and low clocks
  task automatic measure(input logic p, output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while ((p ? phase2DriveOn : phase1DriveOn) !== 1'b0 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    while ((p ? phase2DriveOn : phase1DriveOn) !== 1'b1 && n < 600) begin
      @(negedge clk_sys);
      n++;
    end
    while ((p ? phase2DriveOn : phase1DriveOn) === 1'b1 && h < 300) begin
      @(negedge clk_sys);
      h++;
    end
    while ((p ? phase2DriveOn : phase1DriveOn) === 1'b0 && l < 300) begin
      @(negedge clk_sys);
      l++;
    end
  endtask : measure
  task automatic t_reset();
    check({phase1DriveOn, phase2DriveOn, spiMisoOe}, 3'h0, "idle outputs");
    rdc(`BPT_ADDR_GATE_EN, 8'h00, "gate reset");
    $display("reset test done");
  endtask : t_reset
  task automatic t_regs();
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    wr(`BPT_ADDR_DIV1, 8'hFF);
    wr(`BPT_ADDR_DIV2, 8'h00);
    check(firstOutputCfg.oscDivisor, 8'hFF, "div1");
    check(secondOutputCfg.oscDivisor, 8'h00, "div2");
    // delay code 1F, the recommended 32 periods
    wr(`BPT_ADDR_PHASE1, 8'hFF);
    wr(`BPT_ADDR_PHASE2, 8'h00);
    check({firstOutputCfg.interphaseDelay, firstOutputCfg.offTime}, 8'hFF, "phase1");
    check({secondOutputCfg.interphaseDelay, secondOutputCfg.offTime}, 8'h00, "phase2");
    wr(`BPT_ADDR_PROP, 8'hA5);
    wr(`BPT_ADDR_INTEG, 8'h3C);
    check({secondOutputCfg.propGain, firstOutputCfg.propGain}, 8'hA5, "prop");
    check({secondOutputCfg.integralGain, firstOutputCfg.integralGain}, 8'h3C, "integ");
    rdc(`BPT_ADDR_INTEG, 8'h3C, "integ read");
    foreach (codes[k]) begin
      wr(`BPT_ADDR_SLOPE, {codes[k], codes[4 - k]});
      check({secondOutputCfg.slopeComp, firstOutputCfg.slopeComp}, {codes[k], codes[4 - k]}, "slope");
    end
    for (int k = 0; k < 4; k++) begin
      wr(`BPT_ADDR_SENSE, {4'h0, 2'(k), ~2'(k)});
      check({driver2Cfg, driver1Cfg}, {2'(k), ~2'(k)}, "sense");
    end
    rdc(7'h20, 8'h00, "unmapped");
    $display("register test done");
  endtask : t_regs
  task automatic t_phase();
    // timing chosen for short bench spans
    wr(`BPT_ADDR_DIV1, 8'h02);
    wr(`BPT_ADDR_PHASE1, {5'h03, 3'h1});
    wr(`BPT_ADDR_PHASE2, {5'h04, 3'h0});
    wr(`BPT_ADDR_GATE_EN, 8'h03);
    @(negedge clk_sys) configFinished = 1'b1;
    wr(`BPT_ADDR_DIV1, 8'h07);
    check(firstOutputCfg.oscDivisor, 8'h02, "locked div");
    rdc(`BPT_ADDR_GATE_EN, 8'h03, "gate read");
    @(negedge clk_sys) outputEnable = 2'h3;
    measure(1'b0, hi, lo);
    check(hi, 9, "p1 high");
    check(lo, 3, "p1 low");
    measure(1'b1, hi, lo);
    check(hi, 4, "p2 high");
    check(lo, 1, "p2 low");
    $display("phase test done");
  endtask : t_phase
  task automatic t_disable();
    @(negedge clk_sys) outputEnable = 2'h2;
    repeat (2) @(negedge clk_sys);
    check(phase1DriveOn, 1'b0, "p1 off");
    @(negedge clk_sys) outputEnable = 2'h3;
    measure(1'b0, hi, lo);
    check(hi, 9, "p1 restart");
    @(negedge clk_sys) configFinished = 1'b0;
    wr(`BPT_ADDR_GATE_EN, 8'h02);
    hi = 0;
    repeat (24) @(negedge clk_sys) hi += phase1DriveOn;
    check(hi, 0, "gate bit off");
    $display("disable test done");
  endtask : t_disable
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset();
    t_regs();
    t_phase();
    t_disable();
    close_out();
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    close_out();
  end
endmodule : tb
